// File: logic/link_wake_pkg.sv
package link_wake_pkg;

   // register indices inside the PHY register space
   localparam logic [3:0] IDX_PORT_STATUS = 4'h0;
   localparam logic [3:0] IDX_PORT_CONTROL = 4'h2;
   localparam logic [3:0] IDX_NODE_WAKE = 4'h5;

   // field positions
   localparam int WAKE_PERMIT_BIT = 0;
   localparam int STAT_CON_BIT = 5;
   localparam int STAT_BIAS_BIT = 6;
   localparam int STAT_DISABLED_BIT = 7;
   localparam int CTL_NOTIFY_BIT = 0;
   localparam int CTL_CMD_LSB = 1;
   localparam int CMD_W = 3;
   localparam int CTL_FAULT_BIT = 5;

   // control commands carried in the command field
   localparam logic [2:0] CMD_BEGIN_DISABLE = 3'h2;
   localparam logic [2:0] CMD_BEGIN_ENABLE = 3'h3;

   // reset values
   localparam logic WAKE_PERMIT_RESET = 1'b0;
   localparam logic NOTIFY_RESET = 1'b0;

   // timing
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int RESUME_HOLD_OFF_NS = 1000;
   localparam int DISABLE_HOLD_NS = 2000;
   localparam int RESET_SENSE_NS = 1500;
   localparam int ARB_SENSE_INTERVALS = 3;
   localparam int RESUME_HOLD_OFF_CYC =
      (RESUME_HOLD_OFF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int DISABLE_HOLD_CYC = (DISABLE_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int ARB_TIMEOUT_CYC =
      (ARB_SENSE_INTERVALS * RESET_SENSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int TIMER_W = 16;

   typedef struct packed {
      logic [3:0] index;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed {
      logic for_me;
      reg_write_t wr;
   } irw_packet_t;

   typedef struct packed {
      logic arb_req;
      logic irw_send;
      logic short_reset;
      logic long_reset;
      logic outbound_disable;
      logic bias_level;
      logic bias_oe_n;
   } ctl_out_t;

   localparam ctl_out_t CTL_RESET = 7'h02;

endpackage : link_wake_pkg

// File: logic/hold_timer.sv
`timescale 1ns/10ps
module hold_timer
   import link_wake_pkg::*;
#(
   parameter int W = TIMER_W
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic busy,
   output logic done
);

   logic [W-1:0] count;

   // done marks the last counted cycle so the caller switches on the next edge
   assign busy = count != '0;
   assign done = count == W'(1);

   always_ff @(posedge clock) begin
      if (srst) begin
         count <= '0;
      end else if (start) begin
         count <= load;
      end else if (busy) begin
         count <= count - W'(1);
      end
   end

endmodule : hold_timer

// File: logic/port_disable_and_link_wake.sv
`timescale 1ns/10ps
// Functional notes
// - resume seen while a suspend is in progress is passed inward after the hold-off time.
// - a begin-disable write to the port control register disables the port.
// - an indexed register write addressed to this node is answered by a response.
// - finishing a disable after a packet or a won arbitration issues a short reset and drives the disable signal for hold time.
// - after the disable signal ends the bias generator is switched off to high impedance.
// - a link disable request arbitrates, then broadcasts a begin-disable register write.
// - arbitration lost for three sense intervals gives long reset, disable signal, bias off.
// - the disabled bit clears only through an indexed register write, never connect events.
// - a cabled disabled port reports connected and disabled in status index 0, control at 2.
// - far bias seen bit is set for a legacy peer and clear for a capable one once the disable signal has been driven.
// - a status change with notify enabled and link powered sends a 4-bit status packet.
// - with link unpowered a notified status change wakes the link only if wake is permitted.
// - with wake permitted and link unpowered any resume event wakes the link regardless of notify enables.
// - the wake line rises only from a resume or a notified status change, never with link powered or wake forbidden.
// - the node wake-permit bit is bit 0 of node register 5.
// - only the link changes the wake-permit bit; packet writes to it are ignored.
module port_disable_and_link_wake
   import link_wake_pkg::*;
#(
   parameter int RESUME_HOLD_CYCLES = RESUME_HOLD_OFF_CYC,
   parameter int DISABLE_HOLD_CYCLES = DISABLE_HOLD_CYC,
   parameter int ARB_LIMIT_CYCLES = ARB_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic reg_wr_valid,
   input wire reg_write_t reg_wr,
   input wire logic [3:0] reg_rd_index,
   output logic [7:0] reg_rd_data,
   input wire logic irw_rx_valid,
   input wire irw_packet_t irw_rx,
   input wire logic arb_won,
   input wire logic resume_event,
   input wire logic suspend_busy,
   input wire logic bias_fault,
   input wire logic cable_connected_pin,
   input wire logic far_bias_pin,
   input wire logic lps_pin,
   output logic arb_req,
   output logic irw_send,
   output reg_write_t irw_send_data,
   output logic resp_send,
   output logic short_reset_req,
   output logic long_reset_req,
   output logic outbound_disable_signal,
   output logic bias_out,
   output logic bias_oe_n,
   output logic resume_inward,
   output logic status_packet,
   output logic [3:0] status_packet_data,
   output logic link_wake_signal
);

   typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_SEND, ST_HOLD, ST_DISABLED} disable_state_t;

   disable_state_t state, next_state;
   ctl_out_t ctl, next_ctl;
   logic [2:0] pin_meta, pin_sync;
   logic disabled, notify_en, wake_permit;
   logic [3:0] status_prev;
   logic [7:0] status_byte, control_byte;
   logic timer_start, timer_done, hold_busy, hold_done;
   logic [TIMER_W-1:0] timer_load;

   always_ff @(posedge clock) begin
      if (srst) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {lps_pin, far_bias_pin, cable_connected_pin};
         pin_sync <= pin_meta;
      end
   end

   wire link_power_status = pin_sync[2];
   // a legacy peer keeps its bias up toward a disabled port, a capable one drops it
   wire far_bias_seen = pin_sync[1];
   wire cable_connected = pin_sync[0];
   wire link_ctrl_wr = reg_wr_valid && reg_wr.index == IDX_PORT_CONTROL;
   wire [2:0] link_cmd = reg_wr.data[CTL_CMD_LSB +: CMD_W];
   wire link_disable_req = link_ctrl_wr && link_cmd == CMD_BEGIN_DISABLE;
   wire link_wake_wr = reg_wr_valid && reg_wr.index == IDX_NODE_WAKE;
   wire irw_me = irw_rx_valid && irw_rx.for_me;
   wire irw_ctrl = irw_me && irw_rx.wr.index == IDX_PORT_CONTROL;
   wire [2:0] irw_cmd = irw_rx.wr.data[CTL_CMD_LSB +: CMD_W];
   wire irw_disable = irw_ctrl && irw_cmd == CMD_BEGIN_DISABLE;
   wire irw_enable = irw_ctrl && irw_cmd == CMD_BEGIN_ENABLE;
   wire [3:0] status_now = {far_bias_seen, disabled, cable_connected, bias_fault};
   wire status_change = status_now != status_prev;
   wire notified_change = status_change && notify_en;
   // a notified port change in a sleeping node counts as a resume event
   wire wake_trigger = !link_power_status && wake_permit &&
                       (resume_event || notified_change);
   wire hold_start = resume_event && suspend_busy && !hold_busy;
   hold_timer #(.W(TIMER_W)) seq_timer (
      .clock(clock),
      .srst(srst),
      .start(timer_start),
      .load(timer_load),
      .busy(),
      .done(timer_done)
   );
   hold_timer #(.W(TIMER_W)) resume_timer (
      .clock(clock),
      .srst(srst),
      .start(hold_start),
      .load(TIMER_W'(RESUME_HOLD_CYCLES)),
      .busy(hold_busy),
      .done(hold_done)
   );
   always_comb begin
      next_state = state;
      next_ctl = ctl;
      next_ctl.irw_send = 1'b0;
      next_ctl.short_reset = 1'b0;
      next_ctl.long_reset = 1'b0;
      timer_start = 1'b0;
      timer_load = TIMER_W'(DISABLE_HOLD_CYCLES);
      unique case (state)
         ST_IDLE, ST_ARB: begin
            if (irw_disable) begin
               next_state = ST_HOLD;
               next_ctl.arb_req = 1'b0;
               next_ctl.short_reset = 1'b1;
               next_ctl.outbound_disable = 1'b1;
               timer_start = 1'b1;
            end else if (state == ST_IDLE && link_disable_req) begin
               next_state = ST_ARB;
               next_ctl.arb_req = 1'b1;
               timer_start = 1'b1;
               timer_load = TIMER_W'(ARB_LIMIT_CYCLES);
            end else if (state == ST_ARB && arb_won) begin
               next_state = ST_SEND;
               next_ctl.arb_req = 1'b0;
               next_ctl.irw_send = 1'b1;
            end else if (state == ST_ARB && timer_done) begin
               next_state = ST_HOLD;
               next_ctl.arb_req = 1'b0;
               next_ctl.long_reset = 1'b1;
               next_ctl.outbound_disable = 1'b1;
               timer_start = 1'b1;
            end
         end
         ST_SEND: begin
            next_state = ST_HOLD;
            next_ctl.short_reset = 1'b1;
            next_ctl.outbound_disable = 1'b1;
            timer_start = 1'b1;
         end
         ST_HOLD: begin
            // resets coming back from either kind of peer do not cut the hold short
            if (timer_done) begin
               next_state = ST_DISABLED;
               next_ctl.outbound_disable = 1'b0;
               next_ctl.bias_level = 1'b0;
               next_ctl.bias_oe_n = 1'b1;
            end
         end
         ST_DISABLED: begin
            if (irw_enable) begin
               next_state = ST_IDLE;
               next_ctl.bias_level = 1'b1;
               next_ctl.bias_oe_n = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= ST_IDLE;
         ctl <= CTL_RESET;
      end else begin
         state <= next_state;
         ctl <= next_ctl;
      end
   end

   // connect and disconnect never touch this bit
   always_ff @(posedge clock) begin
      if (srst) begin
         disabled <= 1'b0;
      end else if (next_state == ST_HOLD && state != ST_HOLD) begin
         disabled <= 1'b1;
      end else if (state == ST_DISABLED && irw_enable) begin
         disabled <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         notify_en <= NOTIFY_RESET;
         wake_permit <= WAKE_PERMIT_RESET;
      end else begin
         if (link_ctrl_wr) begin
            notify_en <= reg_wr.data[CTL_NOTIFY_BIT];
         end else if (irw_ctrl) begin
            notify_en <= irw_rx.wr.data[CTL_NOTIFY_BIT];
         end
         // packet writes to the node register are dropped on purpose
         if (link_wake_wr) begin
            wake_permit <= reg_wr.data[WAKE_PERMIT_BIT];
         end
      end
   end

   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_CON_BIT] = cable_connected;
      status_byte[STAT_BIAS_BIT] = far_bias_seen;
      status_byte[STAT_DISABLED_BIT] = disabled;
      control_byte = 8'h00;
      control_byte[CTL_NOTIFY_BIT] = notify_en;
      control_byte[CTL_FAULT_BIT] = bias_fault;
   end

   wire [7:0] read_mux = (reg_rd_index == IDX_PORT_STATUS) ? status_byte :
                         (reg_rd_index == IDX_PORT_CONTROL) ? control_byte :
                         (reg_rd_index == IDX_NODE_WAKE) ? {7'h00, wake_permit} : 8'h00;
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rd_data <= 8'h00;
         resp_send <= 1'b0;
         irw_send_data <= '0;
         status_prev <= 4'h0;
         status_packet <= 1'b0;
         status_packet_data <= 4'h0;
         link_wake_signal <= 1'b0;
         resume_inward <= 1'b0;
      end else begin
         reg_rd_data <= read_mux;
         resp_send <= irw_me;
         irw_send_data <= '{index: IDX_PORT_CONTROL, data: {4'h0, CMD_BEGIN_DISABLE, notify_en}};
         status_prev <= status_now;
         status_packet <= notified_change && link_power_status;
         status_packet_data <= status_now;
         if (wake_trigger) begin
            link_wake_signal <= 1'b1;
         end else if (link_power_status || !wake_permit) begin
            link_wake_signal <= 1'b0;
         end
         resume_inward <= (resume_event && !suspend_busy && !hold_busy) || hold_done;
      end
   end

   assign arb_req = ctl.arb_req;
   assign irw_send = ctl.irw_send;
   assign short_reset_req = ctl.short_reset;
   assign long_reset_req = ctl.long_reset;
   assign outbound_disable_signal = ctl.outbound_disable;
   assign bias_out = ctl.bias_level;
   assign bias_oe_n = ctl.bias_oe_n;
   logic [15:0] arb_cnt;
   always_ff @(posedge clock) begin
      if (srst || !arb_req) begin
         arb_cnt <= 16'h0000;
      end else begin
         arb_cnt <= arb_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   a_resume_hold_off: assert property (hold_start |=> !resume_inward [*2])
      else $error("resume passed inward during hold-off");
   a_ctrl_disable: assert property (irw_disable && state == ST_IDLE
      |=> disabled && outbound_disable_signal) else $error("packet did not disable port");
   a_response_sent: assert property (irw_me |=> resp_send)
      else $error("no response to addressed register write");
   a_disable_drive: assert property ($rose(outbound_disable_signal)
      && !long_reset_req |-> short_reset_req ##1 outbound_disable_signal [*7])
      else $error("disable signal without short reset or cut short");
   a_bias_release: assert property ($fell(outbound_disable_signal)
      |-> bias_oe_n && !bias_out) else $error("bias still driven after disable signal");
   a_broadcast_win: assert property (irw_send |-> $past(arb_req && arb_won)
      && irw_send_data.index == IDX_PORT_CONTROL) else $error("broadcast without a win");
   a_arb_timeout: assert property (long_reset_req
      |-> arb_cnt == 16'(ARB_LIMIT_CYCLES) && outbound_disable_signal)
      else $error("long reset at wrong arbitration count");
   a_disabled_sticky: assert property (disabled
      && !(irw_enable && state == ST_DISABLED) |=> disabled) else $error("disabled bit lost");
   a_status_packet: assert property (status_packet
      |-> $past(link_power_status && notify_en && status_change)) else $error("status packet without cause");
   a_wake_gate: assert property ($rose(link_wake_signal)
      |-> $past(wake_permit && !link_power_status)) else $error("wake raised while powered or forbidden");
   a_wake_resume: assert property (resume_event && wake_permit && !link_power_status
      |=> link_wake_signal) else $error("resume did not wake the link");
   a_node_reg_locked: assert property (irw_me && irw_rx.wr.index == IDX_NODE_WAKE
      && !link_wake_wr |=> $stable(wake_permit)) else $error("packet changed wake-permit bit");

   c_disable_done: cover property (state == ST_HOLD ##1 state == ST_DISABLED);
   c_arb_timeout: cover property (long_reset_req);
   c_wake_rise: cover property ($rose(link_wake_signal));
   c_status_sent: cover property (status_packet);

endmodule : port_disable_and_link_wake

// File: verification/far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
   input wire logic clock,
   input wire logic arb_req,
   input wire logic outbound_disable_signal,
   input wire logic [7:0] grant_delay,
   input wire logic legacy,
   output logic arb_won,
   output logic far_bias_pin,
   output logic long_reset_reply
);
   int wait_n = 0;
   initial begin
      arb_won = 1'b0;
      far_bias_pin = 1'b1;
      long_reset_reply = 1'b0;
   end
   // a delay of 0 never grants, as on a bus kept busy by others
   always @(posedge clock) begin
      wait_n <= arb_req ? wait_n + 1 : 0;
      arb_won <= arb_req && grant_delay != 8'h00 && wait_n + 1 == grant_delay;
      if (legacy)
         far_bias_pin <= 1'b1;
      else if (outbound_disable_signal)
         far_bias_pin <= 1'b0;
      long_reset_reply <= outbound_disable_signal && legacy;
   end
endmodule : far_side_model

// File: verification/port_disable_and_link_wake_test.sv
`timescale 1ns/10ps
module port_disable_and_link_wake_test;
   import link_wake_pkg::*;
   localparam int RH = 4;
   localparam int DH = 8;
   localparam int AL = 10;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic reg_wr_valid = 1'b0;
   reg_write_t reg_wr = '0;
   logic [3:0] reg_rd_index = 4'h0;
   logic irw_rx_valid = 1'b0;
   irw_packet_t irw_rx = '0;
   logic resume_event = 1'b0;
   logic suspend_busy = 1'b0;
   logic bias_fault = 1'b0;
   logic con_pin = 1'b1;
   logic lps_pin = 1'b0;
   logic [7:0] grant_delay = 8'h03;
   logic legacy = 1'b0;
   logic arb_won, far_bias_pin, arb_req, irw_send, resp_send, short_reset_req;
   logic long_reset_req, outbound_disable_signal, bias_out, bias_oe_n, resume_inward;
   logic status_packet, link_wake_signal;
   reg_write_t irw_send_data;
   logic [7:0] reg_rd_data;
   logic [3:0] status_packet_data;
   logic [3:0] exp_q[$];
   int m_permit = 0;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   int n;

   port_disable_and_link_wake #(.RESUME_HOLD_CYCLES(RH), .DISABLE_HOLD_CYCLES(DH),
      .ARB_LIMIT_CYCLES(AL)) dut_u (.clock(clock), .srst(srst), .reg_wr_valid(reg_wr_valid),
      .reg_wr(reg_wr), .reg_rd_index(reg_rd_index), .reg_rd_data(reg_rd_data),
      .irw_rx_valid(irw_rx_valid), .irw_rx(irw_rx), .arb_won(arb_won),
      .resume_event(resume_event), .suspend_busy(suspend_busy), .bias_fault(bias_fault),
      .cable_connected_pin(con_pin), .far_bias_pin(far_bias_pin), .lps_pin(lps_pin),
      .arb_req(arb_req), .irw_send(irw_send), .irw_send_data(irw_send_data),
      .resp_send(resp_send), .short_reset_req(short_reset_req),
      .long_reset_req(long_reset_req), .outbound_disable_signal(outbound_disable_signal),
      .bias_out(bias_out), .bias_oe_n(bias_oe_n), .resume_inward(resume_inward),
      .status_packet(status_packet), .status_packet_data(status_packet_data),
      .link_wake_signal(link_wake_signal));
   far_side_model far_u (.clock(clock), .arb_req(arb_req),
      .outbound_disable_signal(outbound_disable_signal), .grant_delay(grant_delay),
      .legacy(legacy), .arb_won(arb_won), .far_bias_pin(far_bias_pin), .long_reset_reply());

   initial begin
      forever #10 clock = ~clock;
   end

   task test_done;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task chk_count(input int got, input int exp);
      checks++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_count

   task wr_reg(input logic [3:0] idx, input logic [7:0] d);
      @(posedge clock);
      reg_wr_valid <= 1'b1;
      reg_wr <= '{index: idx, data: d};
      @(posedge clock);
      reg_wr_valid <= 1'b0;
   endtask : wr_reg

   task irw(input logic me, input logic [3:0] idx, input logic [7:0] d);
      @(posedge clock);
      irw_rx_valid <= 1'b1;
      irw_rx <= '{for_me: me, wr: '{index: idx, data: d}};
      @(posedge clock);
      irw_rx_valid <= 1'b0;
      #1 chk_byte({7'h0, resp_send}, {7'h0, me});
   endtask : irw

   task rd_reg(input logic [3:0] idx, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clock);
      reg_rd_index <= idx;
      repeat (6) @(posedge clock);
      #1 chk_byte(reg_rd_data & mask, exp);
   endtask : rd_reg

   task pulse_resume;
      @(posedge clock);
      resume_event <= 1'b1;
      @(posedge clock);
      resume_event <= 1'b0;
   endtask : pulse_resume

   task watch_disable(input logic lng);
      n = 0;
      while (outbound_disable_signal !== 1'b1 && n < 400) begin
         @(posedge clock);
         #1 n++;
      end
      chk_byte({6'h0, long_reset_req, short_reset_req}, {6'h0, lng, !lng});
      n = 0;
      while (outbound_disable_signal === 1'b1 && n < 400) begin
         @(posedge clock);
         #1 n++;
      end
      chk_count(n, DH);
      chk_byte({6'h0, bias_out, bias_oe_n}, 8'h01);
   endtask : watch_disable

   // packets and wake are judged against the model as they appear
   always @(negedge clock) begin
      if (!srst && status_packet === 1'b1)
         chk_byte({4'h0, status_packet_data}, {4'h0, exp_q.pop_front()});
      if (!srst && link_wake_signal === 1'b1 && m_permit == 0)
         chk_byte(8'h01, 8'h00);
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      void'($urandom(32'h7715ae78));
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      #1 chk_byte({5'h0, link_wake_signal, bias_out, bias_oe_n}, 8'h02);
      rd_reg(IDX_PORT_STATUS, 8'he0, 8'h60);
      wr_reg(4'h9, 8'($urandom()));
      rd_reg(4'h9, 8'hff, 8'h00);
      $display("test reset done");
      grant_delay <= 8'($urandom_range(1, 8));
      wr_reg(IDX_PORT_CONTROL, 8'h04);
      #1 chk_byte({7'h0, arb_req}, 8'h01);
      for (n = 0; n < 20 && irw_send !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk_byte(irw_send_data.data, 8'h04);
      chk_byte({4'h0, irw_send_data.index}, 8'h02);
      watch_disable(1'b0);
      rd_reg(IDX_PORT_STATUS, 8'he0, 8'ha0);
      con_pin <= 1'b0;
      rd_reg(IDX_PORT_STATUS, 8'he0, 8'h80);
      con_pin <= 1'b1;
      irw(1'b1, IDX_PORT_CONTROL, 8'h06);
      chk_byte({7'h0, bias_oe_n}, 8'h00);
      rd_reg(IDX_PORT_STATUS, 8'he0, 8'h20);
      $display("test link disable done");
      legacy <= 1'b1;
      grant_delay <= 8'h00;
      wr_reg(IDX_PORT_CONTROL, 8'h04);
      // let the request flop settle before looking at it
      #1 n = 0;
      while (arb_req === 1'b1 && n < 400) begin
         @(posedge clock);
         #1 n++;
      end
      chk_count(n, AL);
      watch_disable(1'b1);
      rd_reg(IDX_PORT_STATUS, 8'he0, 8'he0);
      irw(1'b1, IDX_PORT_CONTROL, 8'h06);
      $display("test arbitration timeout done");
      irw(1'b0, IDX_PORT_CONTROL, 8'h04);
      irw(1'b1, IDX_PORT_CONTROL, 8'h04);
      watch_disable(1'b0);
      irw(1'b1, IDX_PORT_CONTROL, 8'h06);
      $display("test packet disable done");
      pulse_resume();
      #1 chk_byte({7'h0, resume_inward}, 8'h01);
      suspend_busy <= 1'b1;
      pulse_resume();
      for (n = 0; n < 40 && resume_inward !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk_byte({7'h0, n >= RH - 1 && n <= RH + 1}, 8'h01);
      suspend_busy <= 1'b0;
      $display("test resume hold-off done");
      irw(1'b1, IDX_NODE_WAKE, 8'h01);
      rd_reg(IDX_NODE_WAKE, 8'hff, 8'h00);
      pulse_resume();
      m_permit = 1;
      wr_reg(IDX_NODE_WAKE, 8'h01);
      pulse_resume();
      @(posedge clock);
      #1 chk_byte({7'h0, link_wake_signal}, 8'h01);
      lps_pin <= 1'b1;
      repeat (5) @(posedge clock);
      #1 chk_byte({7'h0, link_wake_signal}, 8'h00);
      wr_reg(IDX_PORT_CONTROL, 8'h01);
      exp_q.push_back(4'hb);
      bias_fault <= 1'b1;
      pulse_resume();
      repeat (4) @(posedge clock);
      #1 chk_byte({link_wake_signal, 7'(exp_q.size())}, 8'h00);
      rd_reg(IDX_PORT_CONTROL, 8'hff, 8'h21);
      lps_pin <= 1'b0;
      repeat (5) @(posedge clock);
      bias_fault <= 1'b0;
      repeat (3) @(posedge clock);
      #1 chk_byte({7'h0, link_wake_signal}, 8'h01);
      wr_reg(IDX_NODE_WAKE, 8'h00);
      repeat (2) @(posedge clock);
      m_permit = 0;
      $display("test wake done");
      test_done();
   end
endmodule : port_disable_and_link_wake_test
